// File: rtl/pls_defines.svh
/*
 * Constants of the pedal priority latch and divider: pedal count, time units,
 * delays, divisor table.
 * Assumes the pedal clock pin runs at the rate that the mode pin selects.
 */
// How it works
// - Thirteen pedals, clock pin, mode pin, five tone outputs, two triggers.
// - First pedal press starts a key-dependent delay of 4 to 8 ms.
// - A pedal released before its delay ends is dropped; latch unchanged.
// - Release of held pedal restarts delay; right pedals wait unless already held.
// - A newly pressed pedal left of the current one is taken at once.
// - Pressing the latched pedal again clears the tone counters.
// - Accepted note appears as 50 percent squares in five octaves.
// - Tone outputs keep running after release until another pedal wins.
// - With several pedals held only the leftmost, lowest note is chosen.
// - A press of a priority pedal gives a percussion pulse when no pulse is already running.
// - Releasing the left one of two held pedals gives a percussion pulse.
// - Sustain is active while any pedal is held, free of contact bounce.
// - Delays scale with the pedal clock rate, as the timing follows it.
// - Two presses inside one percussion pulse give only one pulse.
`ifndef PLS_DEFINES_SVH
`define PLS_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define PLS_NUM_PEDALS   13
`define PLS_NUM_OCTAVES  5
`define PLS_IDX_NONE     4'hf
`define PLS_IDX_FIRST    4'h0
`define PLS_IDX_LAST     4'hc
`define PLS_PRESCALE_MAX 2'h3

// ****************************************************************
// Time, in units of one slow-mode pedal clock period
// ****************************************************************
`define PLS_UNIT_NS      2000
`define PLS_QUAL_MIN_MS  4
`define PLS_QUAL_MAX_MS  8
`define PLS_TP_MS        10
`define PLS_SUS_DB_MS    1
`define PLS_MS_TO_UNITS(ms) (((ms) * 1000000) / `PLS_UNIT_NS)
`define PLS_QUAL_MIN     `PLS_MS_TO_UNITS(`PLS_QUAL_MIN_MS)
`define PLS_QUAL_MAX     `PLS_MS_TO_UNITS(`PLS_QUAL_MAX_MS)
`define PLS_TP_UNITS     `PLS_MS_TO_UNITS(`PLS_TP_MS)
`define PLS_SUS_DB       13'(`PLS_MS_TO_UNITS(`PLS_SUS_DB_MS))

// ****************************************************************
// Top-octave divisors, pedal clock units per output period
// ****************************************************************
`define PLS_DIV_0  10'd956
`define PLS_DIV_1  10'd902
`define PLS_DIV_2  10'd852
`define PLS_DIV_3  10'd804
`define PLS_DIV_4  10'd758
`define PLS_DIV_5  10'd716
`define PLS_DIV_6  10'd676
`define PLS_DIV_7  10'd638
`define PLS_DIV_8  10'd602
`define PLS_DIV_9  10'd568
`define PLS_DIV_10 10'd536
`define PLS_DIV_11 10'd506
`define PLS_DIV_12 10'd478

`endif

// File: rtl/pls_pkg.sv
/*
 * Types shared by the pedal priority latch and divider.
 * Assumes pls_defines.svh is on the include path.
 */
`include "pls_defines.svh"

package pls_pkg;

   typedef logic [3:0]                    pls_idx_t;
   typedef logic [12:0]                   pls_cnt_t;
   typedef logic [9:0]                    pls_div_t;
   typedef logic [`PLS_NUM_PEDALS-1:0]    pls_pedals_t;
   typedef logic [`PLS_NUM_OCTAVES-1:0]   pls_octaves_t;

   typedef struct packed {
      logic percussion_trigger;
      logic sustain_trigger;
   } pls_trig_t;

endpackage : pls_pkg

// File: rtl/pls_pedal_latch.sv
/*
 * Pedal priority latch and five-octave divider with sustain and
 * percussion triggers.
 * Assumes pedals and the pedal clock come straight from pins (asynchronous)
 * and that mclk_i is far faster than the pedal clock.
 */
`timescale 1ns/100ps
`include "pls_defines.svh"

module pls_pedal_latch (
   // System
   input  wire logic                mclk_i,
   input  wire logic                rst_i,
   // Pins from the organ
   input  wire pls_pkg::pls_pedals_t pedal_n_i,
   input  wire logic                pedal_clk_i,
   input  wire logic                mode_i,
   // Tone and trigger outputs
   output pls_pkg::pls_octaves_t    freq_o,
   output pls_pkg::pls_trig_t       trig_o
);
   import pls_pkg::*;

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Leftmost set bit, pedal_input_first being index 0
   function automatic pls_idx_t leftmost(input pls_pedals_t v);
      pls_idx_t r;
      r = `PLS_IDX_NONE;
      for (int i = `PLS_NUM_PEDALS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // Delay grows linearly from leftmost to rightmost pedal
   function automatic pls_cnt_t qual_delay(input pls_idx_t k);
      int d;
      d = `PLS_QUAL_MIN + (int'(k) * (`PLS_QUAL_MAX - `PLS_QUAL_MIN))
          / int'(`PLS_IDX_LAST);
      return 13'(d);
   endfunction

   // Half period of the top octave in units
   function automatic pls_div_t half_div(input pls_idx_t k);
      pls_div_t d;
      unique case (k)
         4'h0:    d = `PLS_DIV_0;
         4'h1:    d = `PLS_DIV_1;
         4'h2:    d = `PLS_DIV_2;
         4'h3:    d = `PLS_DIV_3;
         4'h4:    d = `PLS_DIV_4;
         4'h5:    d = `PLS_DIV_5;
         4'h6:    d = `PLS_DIV_6;
         4'h7:    d = `PLS_DIV_7;
         4'h8:    d = `PLS_DIV_8;
         4'h9:    d = `PLS_DIV_9;
         4'ha:    d = `PLS_DIV_10;
         4'hb:    d = `PLS_DIV_11;
         default: d = `PLS_DIV_12;
      endcase
      return d >> 1;
   endfunction

   // Count down to zero and stay there
   function automatic pls_cnt_t step_down(input pls_cnt_t v);
      pls_cnt_t r;
      r = v;
      if (v != '0) begin
         r = v - 13'h1;
      end
      return r;
   endfunction

   // True while any pedal is down
   function automatic logic any_down(input pls_pedals_t v);
      return (v != '0);
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   pls_pedals_t ped_s1_q, ped_s2_q, ped_s1_d, ped_s2_d;
   logic        clk_s1_q, clk_s2_q, clk_s1_d, clk_s2_d;
   logic        mode_s1_q, mode_s2_q, mode_s1_d, mode_s2_d;

   always_comb begin
      ped_s1_d  = pedal_n_i;
      ped_s2_d  = ped_s1_q;
      clk_s1_d  = pedal_clk_i;
      clk_s2_d  = clk_s1_q;
      mode_s1_d = mode_i;
      mode_s2_d = mode_s1_q;
      if (rst_i) begin
         ped_s1_d  = '1;
         ped_s2_d  = '1;
         clk_s1_d  = 1'b0;
         clk_s2_d  = 1'b0;
         mode_s1_d = 1'b1;
         mode_s2_d = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      ped_s1_q  <= ped_s1_d;
      ped_s2_q  <= ped_s2_d;
      clk_s1_q  <= clk_s1_d;
      clk_s2_q  <= clk_s2_d;
      mode_s1_q <= mode_s1_d;
      mode_s2_q <= mode_s2_d;
   end

   // ****************************************************************
   // Time base
   // ****************************************************************
   // The fast mode divides its clock by four so both modes share one unit
   logic       clk_prev_q, clk_prev_d;
   logic [1:0] pre_q, pre_d;
   logic       unit;

   always_comb begin
      unit       = 1'b0;
      pre_d      = pre_q;
      clk_prev_d = clk_s2_q;
      if (clk_s2_q && !clk_prev_q) begin
         pre_d = pre_q + 2'h1;
         unit  = mode_s2_q || (pre_q == `PLS_PRESCALE_MAX);
      end
      if (rst_i) begin
         pre_d      = '0;
         clk_prev_d = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      pre_q      <= pre_d;
      clk_prev_q <= clk_prev_d;
   end

   // ****************************************************************
   // Priority, qualification and triggers
   // ****************************************************************
   pls_pedals_t  held, press, rel, held_q, held_d;
   pls_idx_t     sel_q, sel_d, cand_q, cand_d, lm_press, lm_held, acc_idx;
   pls_cnt_t     qual_q, qual_d, lock_q, lock_d, perc_q, perc_d, sus_cnt_q, sus_cnt_d;
   pls_div_t     ncnt_q, ncnt_d;
   pls_octaves_t oct_q, oct_d;
   pls_trig_t    trig_q, trig_d;
   logic         sus_q, sus_d, accept, carry;

   always_comb begin
      held      = ~ped_s2_q;
      press     = held & ~held_q;
      rel       = ~held & held_q;
      lm_press  = leftmost(press);
      lm_held   = leftmost(held);
      held_d    = held;
      sel_d     = sel_q;
      cand_d    = cand_q;
      qual_d    = qual_q;
      lock_d    = lock_q;
      perc_d    = perc_q;
      accept    = 1'b0;
      acc_idx   = sel_q;
      if (unit) begin
         qual_d = step_down(qual_q);
         lock_d = step_down(lock_q);
         perc_d = step_down(perc_q);
      end
      // Candidate waits out its delay while held
      if (cand_q != `PLS_IDX_NONE) begin
         if (rel[cand_q]) begin
            cand_d = `PLS_IDX_NONE;
         end else if (qual_d == '0) begin
            accept  = 1'b1;
            acc_idx = cand_q;
         end
      end
      // Lockout over: a pedal still held now starts its own delay
      if (lock_q != '0 && lock_d == '0 && cand_d == `PLS_IDX_NONE && !accept &&
          lm_held != `PLS_IDX_NONE) begin
         cand_d = lm_held;
         qual_d = qual_delay(lm_held);
      end
      // Release of the latched pedal
      if (sel_q != `PLS_IDX_NONE && rel[sel_q]) begin
         lock_d = qual_delay(sel_q);
         cand_d = `PLS_IDX_NONE;
         if (lm_held != `PLS_IDX_NONE && !press[lm_held]) begin
            accept  = 1'b1;
            acc_idx = lm_held;
         end
      end
      // New presses
      if (lm_press != `PLS_IDX_NONE) begin
         if (sel_q != `PLS_IDX_NONE && lm_press <= sel_q) begin
            accept  = 1'b1;
            acc_idx = lm_press;
         end else if (lock_d == '0 && lm_press == lm_held &&
                      (cand_d == `PLS_IDX_NONE || lm_press < cand_d)) begin
            cand_d = lm_press;
            qual_d = qual_delay(lm_press);
         end
      end
      if (accept) begin
         sel_d  = acc_idx;
         cand_d = `PLS_IDX_NONE;
         lock_d = '0;
         if (perc_q == '0) begin
            perc_d = 13'(`PLS_TP_UNITS);
         end
      end
      trig_d.percussion_trigger = (perc_d != '0);
      trig_d.sustain_trigger    = sus_d;
      if (rst_i) begin
         held_d    = '0;
         sel_d     = `PLS_IDX_NONE;
         cand_d    = `PLS_IDX_NONE;
         qual_d    = '0;
         lock_d    = '0;
         perc_d    = '0;
         trig_d    = '0;
      end
   end

   always_ff @(posedge mclk_i) begin
      held_q    <= held_d;
      sel_q     <= sel_d;
      cand_q    <= cand_d;
      qual_q    <= qual_d;
      lock_q    <= lock_d;
      perc_q    <= perc_d;
      trig_q    <= trig_d;
   end

   // ****************************************************************
   // Tone divider
   // ****************************************************************
   // Counters restart on every accept, so a repress jumps the phase
   always_comb begin
      ncnt_d = ncnt_q;
      oct_d  = oct_q;
      carry  = 1'b1;
      if (accept) begin
         ncnt_d = '0;
         oct_d  = '0;
      end else if (unit && sel_q != `PLS_IDX_NONE) begin
         // Tones free-run while latched, pedal held or not
         if (ncnt_q >= half_div(sel_q) - 10'h1) begin
            ncnt_d = '0;
            for (int i = 0; i < `PLS_NUM_OCTAVES; i++) begin
               if (carry) oct_d[i] = ~oct_q[i];
               carry = carry & oct_q[i];
            end
         end else begin
            ncnt_d = ncnt_q + 10'h1;
         end
      end
      if (rst_i) begin
         ncnt_d = '0;
         oct_d  = '0;
      end
   end

   always_ff @(posedge mclk_i) begin
      ncnt_q <= ncnt_d;
      oct_q  <= oct_d;
   end

   // ****************************************************************
   // Sustain debounce
   // ****************************************************************
   // A slow settle costs a little delay but keeps contact bounce off the envelope
   always_comb begin
      sus_d     = sus_q;
      sus_cnt_d = sus_cnt_q;
      if (unit) begin
         if (any_down(held) != sus_q) begin
            sus_cnt_d = sus_cnt_q + 13'h1;
            if (sus_cnt_q >= `PLS_SUS_DB - 13'h1) begin
               sus_d     = any_down(held);
               sus_cnt_d = '0;
            end
         end else begin
            sus_cnt_d = '0;
         end
      end
      if (rst_i) begin
         sus_d     = 1'b0;
         sus_cnt_d = '0;
      end
   end

   always_ff @(posedge mclk_i) begin
      sus_q     <= sus_d;
      sus_cnt_q <= sus_cnt_d;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign freq_o = oct_q;
   assign trig_o = trig_q;

endmodule // pls_pedal_latch

// File: tb/pls_properties.sv
/* Port checker for pls_pedal_latch.
   Assumes a bind from the bench, every port joined by name. */
`timescale 1ns/100ps
module pls_properties (
   // Watched ports
   input wire logic                  mclk_i,
   input wire logic                  rst_i,
   input wire pls_pkg::pls_pedals_t  pedal_n_i,
   input wire logic                  pedal_clk_i,
   input wire logic                  mode_i,
   input wire pls_pkg::pls_octaves_t freq_o,
   input wire pls_pkg::pls_trig_t    trig_o
);
   import pls_pkg::*;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // ************************************************
   // Properties
   // ************************************************
   sequence s_perc_start;
      $rose(trig_o.percussion_trigger);
   endsequence
   property p_rst_quiet;
      disable iff (1'b0) rst_i |=> (freq_o == '0 && trig_o == '0);
   endproperty
   property p_sus_rise;
      $rose(trig_o.sustain_trigger) |-> $past(pedal_n_i, 4) != '1;
   endproperty
   property p_sus_fall;
      $fell(trig_o.sustain_trigger) |-> $past(pedal_n_i, 4) == '1;
   endproperty
   property p_sus_steady;
      $changed(trig_o.sustain_trigger) |=> $stable(trig_o.sustain_trigger)[*8];
   endproperty
   property p_perc_min;
      s_perc_start |=> trig_o.percussion_trigger[*8];
   endproperty
   property p_perc_held;
      s_perc_start |-> pedal_n_i != '1;
   endproperty
   property p_accept_zero;
      s_perc_start |-> ##[0:2] freq_o == '0;
   endproperty
   property p_oct1;
      $rose(freq_o[1]) |-> !freq_o[0];
   endproperty
   property p_oct4;
      $fell(freq_o[4]) |-> freq_o == '0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not clear after reset");
   a_sus_rise: assert property (p_sus_rise) else $error("sustain rose, no pedal");
   a_sus_fall: assert property (p_sus_fall) else $error("sustain fell, pedal held");
   a_sus_steady: assert property (p_sus_steady) else $error("sustain chatter");
   a_perc_min: assert property (p_perc_min) else $error("percussion too short");
   a_perc_held: assert property (p_perc_held) else $error("percussion, no pedal");
   a_accept_zero: assert property (p_accept_zero) else $error("tones not zeroed");
   a_oct1: assert property (p_oct1) else $error("octave 1 off step");
   a_oct4: assert property (p_oct4) else $error("octave 4 off step");
endmodule // pls_properties

// File: tb/pls_pedal_board.sv
/* Pedal contacts and note clock source facing the latch.
   Assumes the bench sets held_i at the rising edge, one bit a pedal. */
`timescale 1ns/100ps
module pls_pedal_board #(
   parameter int CLK_HALF = 3
) (
   // Clock and bench command
   input  wire logic                 mclk_i,
   input  wire pls_pkg::pls_pedals_t held_i,
   // Pins towards the latch
   output pls_pkg::pls_pedals_t      pedal_n_o,
   output logic                      pedal_clk_o
);
   import pls_pkg::*;
   int cnt_q;
   // One process owns every pin; the clock runs free, far above the real rate
   initial begin
      cnt_q = 0;
      pedal_n_o = '1;
      pedal_clk_o = 1'b0;
      forever begin
         @(posedge mclk_i);
         pedal_n_o <= ~held_i;
         if (cnt_q == CLK_HALF - 1) begin
            cnt_q <= 0;
            pedal_clk_o <= ~pedal_clk_o;
         end else begin
            cnt_q <= cnt_q + 1;
         end
      end
   end
endmodule // pls_pedal_board

// File: tb/pls_pedal_latch_bench.sv
/* Scenario bench for pls_pedal_latch.
   Assumes pls_defines.svh on the include path; one unit is 6 mclk. */
`timescale 1ns/100ps
`include "pls_defines.svh"
module pls_pedal_latch_bench;
   import pls_pkg::*;
   localparam int U = 6;
   // Fast mode expects a clock four times the slow one, so time stretches by four
   localparam int FAST = 4;
   logic         mclk_i = 1'b0;
   logic         rst_i  = 1'b1;
   logic         mode_i = 1'b1;
   pls_pedals_t  held   = '0;
   pls_pedals_t  pedal_n;
   logic         pedal_clk;
   pls_octaves_t freq_o;
   pls_trig_t    trig_o;
   int           fail_count = 0;
   int           checks_done = 0;
   int           cyc = 0;
   int           rise_cyc = 0;
   logic [15:0]  n;

   pls_pedal_latch pls_pedal_latch_i (.mclk_i(mclk_i), .rst_i(rst_i), .pedal_n_i(pedal_n),
      .pedal_clk_i(pedal_clk), .mode_i(mode_i), .freq_o(freq_o), .trig_o(trig_o));
   pls_pedal_board pls_pedal_board_i (.mclk_i(mclk_i), .held_i(held), .pedal_n_o(pedal_n),
      .pedal_clk_o(pedal_clk));

   initial forever #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) cyc <= cyc + 1;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic units(input int k);
      repeat (k * U) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask
   task automatic press(input pls_pedals_t m);
      @(posedge mclk_i) held <= m;
   endtask
   // Cycles of one half period of octave b, bounded wait
   task automatic half(input int b, output logic [15:0] h);
      logic v;
      int   k;
      @(negedge mclk_i) v = freq_o[b];
      for (k = 0; k < 20000 && freq_o[b] === v; k++) @(negedge mclk_i);
      v = freq_o[b];
      for (k = 0; k < 20000 && freq_o[b] === v; k++) @(negedge mclk_i);
      h = 16'(k);
   endtask

   task automatic t_short;
      press(13'h0004);
      units(400);
      chk("sustain early", 0, trig_o.sustain_trigger);
      units(200);
      chk("sustain held", 1, trig_o.sustain_trigger);
      press('0);
      units(600);
      chk("tones after drop", 0, freq_o);
      chk("triggers after drop", 0, trig_o);
      $display("short press done");
   endtask
   task automatic t_qual;
      press(13'h0042);
      units(`PLS_QUAL_MIN + 2000 / 12 - 10);
      chk("perc before delay", 0, trig_o.percussion_trigger);
      units(20);
      rise_cyc = cyc;
      chk("perc after delay", 1, trig_o.percussion_trigger);
      chk("tones restart", 0, freq_o);
      half(0, n);
      chk("top half a", 16'(`PLS_DIV_1 / 2 * U), n);
      half(0, n);
      chk("top half b", 16'(`PLS_DIV_1 / 2 * U), n);
      half(1, n);
      chk("octave 1 half", 16'(`PLS_DIV_1 * U), n);
      $display("qualified press done");
   endtask
   task automatic t_left;
      press(13'h0043);
      repeat (12) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("left accept zero", 0, freq_o);
      half(0, n);
      chk("left note half", 16'(`PLS_DIV_0 / 2 * U), n);
      while (cyc < rise_cyc + `PLS_TP_UNITS * U + 30) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("single pulse", 0, trig_o.percussion_trigger);
      press(13'h0002);
      repeat (12) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("left release pulse", 1, trig_o.percussion_trigger);
      half(0, n);
      chk("right note half", 16'(`PLS_DIV_1 / 2 * U), n);
      press('0);
      units(600);
      chk("sustain off", 0, trig_o.sustain_trigger);
      half(0, n);
      chk("tones keep running", 16'(`PLS_DIV_1 / 2 * U), n);
      $display("left and release done");
   endtask

   task automatic t_mode;
      press(13'h0002);
      repeat (12) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("repress zero", 0, freq_o);
      @(posedge mclk_i) mode_i <= 1'b0;
      half(0, n);
      chk("fast mode half", 16'(`PLS_DIV_1 / 2 * U * FAST), n);
      $display("repress and fast mode done");
   endtask

   task automatic close_out;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_short;
      t_qual;
      t_left;
      t_mode;
      close_out;
   end
   initial begin
      repeat (100000) @(posedge mclk_i);
      fail_count++;
      $display("watchdog expired");
      close_out;
   end
endmodule // pls_pedal_latch_bench

bind pls_pedal_latch pls_properties pls_properties_i (.mclk_i(mclk_i), .rst_i(rst_i),
   .pedal_n_i(pedal_n_i), .pedal_clk_i(pedal_clk_i), .mode_i(mode_i), .freq_o(freq_o),
   .trig_o(trig_o));
